// ==== logic/llb_detector.sv ====
/*
 * Latching loopback detector and loopback datapath of a fractional T1
 * channel unit: arms on the latching sequence in the primary DS0, loops
 * toward network or customer, handles button and craft requests and the
 * optional loopup timeout.
 * Assumes one byte strobe per DS0 slot with both directions aligned, a
 * slot number on each strobe, and button and craft inputs already
 * debounced to one-cycle pulses, all synchronous to clk_sys_i.
 */
// Notes on behaviour
// - Own select code 0x55 starts the network loop; craft may too.
// - Codes are searched only in the primary DS0 slot.
// - Network loop returns used slots to network, still passes on.
// - Customer loop returns used slots to customer, ones to network.
// - Customer unit button press toggles our customer loop.
// - Own button requests far unit network loop, or repeater loop.
// - Button loop released by next press or loopup timeout.
// - Craft commands set or clear local and remote loops.
// - First arming stage: 35 transition marker bytes.
// - Second stage: 35 select code bytes matching our own code.
// - Third stage: 100 loop enable bytes.
// - Final stage: 32 far voice bytes latch the loop when the count of ones stages passed equals tandem_index_i.
// - 25 second watchdog between stages abandons arming.
// - 35 transition marker bytes while looped release the loop.
// - Looped state holds the loop and keeps watching for release.
// - Optional 20 minute timeout, timed from a local or button loop, releases every loop.
// - Select codes of other units are ignored.
`include "llb_regs.svh"
`default_nettype none

module llb_detector
   import llb_pkg::*;
#(
   parameter logic [`LLB_WDOG_W-1:0] WDOG_CYCLES =
      `LLB_WDOG_W'(`LLB_WDOG_CYC),
   parameter logic [`LLB_LOOPUP_W-1:0] LOOPUP_CYCLES =
      `LLB_LOOPUP_W'(`LLB_LOOPUP_CYC)
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic byte_stb_i,
   input wire logic [`LLB_SLOT_W-1:0] slot_i,
   input wire logic [`LLB_SLOT_W-1:0] primary_slot_i,
   input wire logic [`LLB_NUM_SLOTS-1:0] slot_in_use_i,
   input wire logic [7:0] net_rx_byte_i,
   input wire logic [7:0] cust_rx_byte_i,
   input wire logic [`LLB_TANDEM_W-1:0] tandem_index_i,
   input wire logic repeater_present_i,
   input wire logic loopup_timeout_en_i,
   input wire logic remote_loop_button_i,
   input wire logic remote_loop_key_i,
   input wire logic craft_cmd_valid_i,
   input wire logic [3:0] craft_cmd_i,
   output logic tx_stb_o,
   output logic [7:0] net_tx_byte_o,
   output logic [7:0] cust_tx_byte_o,
   output logic net_loop_o,
   output logic cust_loop_o,
   output logic rmt_net_loop_req_o,
   output logic rmt_cust_loop_req_o,
   output logic rpt_loop_req_o,
   output logic [2:0] arm_state_o
);

   localparam logic [7:0] CODE_PAT [`LLB_NUM_CODES] = '{
      `LLB_TIP_BYTE, `LLB_OWN_SEL_BYTE, `LLB_ENA_BYTE,
      `LLB_ONES_BYTE, `LLB_FAR_VOICE_BYTE
   };
   localparam logic [7:0] CODE_MIN [`LLB_NUM_CODES] = '{
      `LLB_TIP_MIN, `LLB_SEL_MIN, `LLB_ENA_MIN,
      `LLB_ONES_MIN, `LLB_FAR_MIN
   };

   llb_arm_state_t arm_q;
   llb_arm_state_t arm_d;
   logic [`LLB_WDOG_W-1:0] wdog_q;
   logic [`LLB_LOOPUP_W-1:0] loopup_q;
   logic [`LLB_TANDEM_W-1:0] iter_q;
   logic net_loop_q;
   logic cust_loop_q;
   logic craft_net_q;
   logic rmt_net_q;
   logic rmt_cust_q;
   logic rpt_q;
   logic btn_rmt_q;

   logic prim_stb;
   logic [`LLB_NUM_CODES-1:0] reach;
   logic [`LLB_NUM_CODES-1:0] run;
   logic wdog_expired;
   logic loopup_expired;
   logic code_latch;
   logic code_release;
   logic arming;
   logic any_loop;
   logic in_use;
   llb_craft_cmd_t cmd;

   assign prim_stb = byte_stb_i && (slot_i == primary_slot_i);
   assign cmd = llb_craft_cmd_t'(craft_cmd_i);

   genvar gi;
   generate
      for (gi = 0; gi < `LLB_NUM_CODES; gi++) begin : g_code
         llb_code_run #(
            .PATTERN(CODE_PAT[gi]),
            .MIN_COUNT(CODE_MIN[gi])
         ) u_run (
            .clk_sys_i(clk_sys_i),
            .sys_rst_i(sys_rst_i),
            .byte_stb_i(prim_stb),
            .byte_i(net_rx_byte_i),
            .reach_o(reach[gi]),
            .run_o(run[gi])
         );
      end
   endgenerate

   assign arming = (arm_q != LLB_IDLE) && (arm_q != LLB_LOOPED);
   assign wdog_expired = arming && (wdog_q >= WDOG_CYCLES - `LLB_WDOG_W'(1));
   assign any_loop = net_loop_q || cust_loop_q || btn_rmt_q;
   assign loopup_expired = loopup_timeout_en_i && any_loop &&
      (loopup_q >= LOOPUP_CYCLES - `LLB_LOOPUP_W'(1));

   // Arming sequence
   always_comb begin
      arm_d = arm_q;
      case (arm_q)
         LLB_IDLE: begin
            if (reach[LLB_CODE_TIP]) begin
               arm_d = LLB_TIP_OK;
            end
         end
         LLB_TIP_OK: begin
            if (reach[LLB_CODE_SEL]) begin
               arm_d = LLB_SEL_OK;
            end
         end
         LLB_SEL_OK: begin
            if (reach[LLB_CODE_ENA]) begin
               arm_d = LLB_ENA_OK;
            end
         end
         LLB_ENA_OK: begin
            if (reach[LLB_CODE_FAR]) begin
               arm_d = (iter_q == tandem_index_i) ? LLB_LOOPED : LLB_IDLE;
            end else if (reach[LLB_CODE_ONES]) begin
               arm_d = LLB_ONES_OK;
            end
         end
         LLB_ONES_OK: begin
            if (reach[LLB_CODE_ENA]) begin
               arm_d = LLB_ENA_OK;
            end
         end
         LLB_LOOPED: begin
            if (reach[LLB_CODE_TIP]) begin
               arm_d = LLB_IDLE;
            end
         end
         default: begin
            arm_d = LLB_IDLE;
         end
      endcase
      if (wdog_expired) begin
         arm_d = LLB_IDLE;
      end
      if (arm_q == LLB_LOOPED && (loopup_expired || !net_loop_q)) begin
         arm_d = LLB_IDLE;
      end
   end

   assign code_latch = (arm_q == LLB_ENA_OK) && (arm_d == LLB_LOOPED);
   assign code_release = (arm_q == LLB_LOOPED) && reach[LLB_CODE_TIP];

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         arm_q <= LLB_IDLE;
      end else begin
         arm_q <= arm_d;
      end
   end

   // Watchdog restarts at every completed stage
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         wdog_q <= '0;
      end else if (!arming || arm_d != arm_q) begin
         wdog_q <= '0;
      end else begin
         wdog_q <= wdog_q + `LLB_WDOG_W'(1);
      end
   end

   // Tandem iteration count
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         iter_q <= '0;
      end else if (arm_d == LLB_IDLE || arm_q == LLB_LOOPED) begin
         iter_q <= '0;
      end else if (arm_q == LLB_ENA_OK && arm_d == LLB_ONES_OK) begin
         iter_q <= iter_q + `LLB_TANDEM_W'(1);
      end
   end

   // Loopup timer runs while a local or button loop stands
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         loopup_q <= '0;
      end else if (!any_loop || loopup_expired) begin
         loopup_q <= '0;
      end else begin
         loopup_q <= loopup_q + `LLB_LOOPUP_W'(1);
      end
   end

   // Network-facing loop
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         net_loop_q <= 1'b0;
         craft_net_q <= 1'b0;
      end else if (loopup_expired || code_release) begin
         net_loop_q <= 1'b0;
         craft_net_q <= 1'b0;
      end else if (code_latch) begin
         net_loop_q <= 1'b1;
      end else if (craft_cmd_valid_i && cmd == LLB_CMD_NET_ON) begin
         net_loop_q <= 1'b1;
         craft_net_q <= 1'b1;
      end else if (craft_cmd_valid_i && cmd == LLB_CMD_NET_OFF) begin
         net_loop_q <= 1'b0;
         craft_net_q <= 1'b0;
      end else if (craft_cmd_valid_i && cmd == LLB_CMD_CUST_ON) begin
         net_loop_q <= 1'b0;
         craft_net_q <= 1'b0;
      end else if (remote_loop_key_i && !cust_loop_q) begin
         net_loop_q <= 1'b0;
         craft_net_q <= 1'b0;
      end
   end

   // Customer-facing loop
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         cust_loop_q <= 1'b0;
      end else if (loopup_expired) begin
         cust_loop_q <= 1'b0;
      end else if (code_latch) begin
         cust_loop_q <= 1'b0;
      end else if (remote_loop_key_i) begin
         cust_loop_q <= !cust_loop_q;
      end else if (craft_cmd_valid_i && cmd == LLB_CMD_CUST_ON) begin
         cust_loop_q <= 1'b1;
      end else if (craft_cmd_valid_i &&
                   (cmd == LLB_CMD_CUST_OFF || cmd == LLB_CMD_NET_ON)) begin
         cust_loop_q <= 1'b0;
      end
   end

   // Own button remote request
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         btn_rmt_q <= 1'b0;
      end else if (loopup_expired) begin
         btn_rmt_q <= 1'b0;
      end else if (remote_loop_button_i) begin
         btn_rmt_q <= !btn_rmt_q;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         rmt_net_q <= 1'b0;
         rmt_cust_q <= 1'b0;
         rpt_q <= 1'b0;
      end else if (loopup_expired) begin
         rmt_net_q <= 1'b0;
         rmt_cust_q <= 1'b0;
         rpt_q <= 1'b0;
      end else if (craft_cmd_valid_i) begin
         case (cmd)
            LLB_CMD_RMT_NET_ON: begin
               rmt_net_q <= 1'b1;
            end
            LLB_CMD_RMT_NET_OFF: begin
               rmt_net_q <= 1'b0;
            end
            LLB_CMD_RMT_CUST_ON: begin
               rmt_cust_q <= 1'b1;
            end
            LLB_CMD_RMT_CUST_OFF: begin
               rmt_cust_q <= 1'b0;
            end
            LLB_CMD_RPT_ON: begin
               rpt_q <= 1'b1;
            end
            LLB_CMD_RPT_OFF: begin
               rpt_q <= 1'b0;
            end
            default: begin
               rpt_q <= rpt_q;
            end
         endcase
      end
   end

   // Button steers to repeater when present
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         rmt_net_loop_req_o <= 1'b0;
         rpt_loop_req_o <= 1'b0;
         rmt_cust_loop_req_o <= 1'b0;
      end else begin
         rmt_net_loop_req_o <= rmt_net_q ||
            (btn_rmt_q && !repeater_present_i);
         rpt_loop_req_o <= rpt_q || (btn_rmt_q && repeater_present_i);
         rmt_cust_loop_req_o <= rmt_cust_q;
      end
   end

   assign in_use = slot_in_use_i[slot_i];

   // Loop datapath, one registered byte per strobe
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         net_tx_byte_o <= `LLB_IDLE_FILL;
         cust_tx_byte_o <= `LLB_IDLE_FILL;
      end else if (byte_stb_i) begin
         if (cust_loop_q && in_use) begin
            // Ones to network, loop to customer
            net_tx_byte_o <= `LLB_IDLE_FILL;
            cust_tx_byte_o <= cust_rx_byte_i;
         end else if (net_loop_q && in_use) begin
            net_tx_byte_o <= net_rx_byte_i;
            cust_tx_byte_o <= net_rx_byte_i;
         end else begin
            net_tx_byte_o <= cust_rx_byte_i;
            cust_tx_byte_o <= net_rx_byte_i;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         tx_stb_o <= 1'b0;
      end else begin
         tx_stb_o <= byte_stb_i;
      end
   end

   assign net_loop_o = net_loop_q;
   assign cust_loop_o = cust_loop_q;
   assign arm_state_o = arm_q;

endmodule : llb_detector

`default_nettype wire

// ==== pkg/llb_regs.svh ====
/*
 * Constants of the latching loopback detector: code bytes, run lengths,
 * slot geometry and timing counts.
 * Assumes a 125 MHz system clock and a 24-slot DS0 frame.
 */
`ifndef LLB_REGS_SVH
`define LLB_REGS_SVH

// Control bit is bit 7; only the low seven bits are compared
`define LLB_CODE_MASK 8'h7f
`define LLB_TIP_BYTE 8'h3a
`define LLB_OWN_SEL_BYTE 8'h55
`define LLB_ENA_BYTE 8'h56
`define LLB_ONES_BYTE 8'h7f
`define LLB_FAR_VOICE_BYTE 8'h5a
`define LLB_IDLE_FILL 8'hff

`define LLB_TIP_MIN 8'd35
`define LLB_SEL_MIN 8'd35
`define LLB_ENA_MIN 8'd100
`define LLB_ONES_MIN 8'd35
`define LLB_FAR_MIN 8'd32

`define LLB_NUM_CODES 5
`define LLB_NUM_SLOTS 24
`define LLB_SLOT_W 5
`define LLB_TANDEM_W 3

`define LLB_CLK_HZ 64'd125000000
`define LLB_WDOG_SEC 64'd25
`define LLB_LOOPUP_MIN 64'd20
`define LLB_SEC_PER_MIN 64'd60
`define LLB_WDOG_CYC (`LLB_WDOG_SEC * `LLB_CLK_HZ)
`define LLB_LOOPUP_CYC (`LLB_LOOPUP_MIN * `LLB_SEC_PER_MIN * `LLB_CLK_HZ)
`define LLB_WDOG_W 32
`define LLB_LOOPUP_W 40

`endif

// ==== pkg/llb_pkg.sv ====
/*
 * Types of the latching loopback detector.
 * Assumes llb_regs.svh for the numeric constants.
 */
`default_nettype none

package llb_pkg;

   typedef enum logic [2:0] {
      LLB_IDLE     = 3'b000,
      LLB_TIP_OK   = 3'b001,
      LLB_SEL_OK   = 3'b010,
      LLB_ENA_OK   = 3'b011,
      LLB_ONES_OK  = 3'b100,
      LLB_LOOPED   = 3'b101
   } llb_arm_state_t;

   typedef enum logic [3:0] {
      LLB_CMD_NET_ON       = 4'h0,
      LLB_CMD_NET_OFF      = 4'h1,
      LLB_CMD_CUST_ON      = 4'h2,
      LLB_CMD_CUST_OFF     = 4'h3,
      LLB_CMD_RMT_NET_ON   = 4'h4,
      LLB_CMD_RMT_NET_OFF  = 4'h5,
      LLB_CMD_RMT_CUST_ON  = 4'h6,
      LLB_CMD_RMT_CUST_OFF = 4'h7,
      LLB_CMD_RPT_ON       = 4'h8,
      LLB_CMD_RPT_OFF      = 4'h9
   } llb_craft_cmd_t;

   typedef enum logic [2:0] {
      LLB_CODE_TIP  = 3'd0,
      LLB_CODE_SEL  = 3'd1,
      LLB_CODE_ENA  = 3'd2,
      LLB_CODE_ONES = 3'd3,
      LLB_CODE_FAR  = 3'd4
   } llb_code_t;

endpackage : llb_pkg

`default_nettype wire

// ==== logic/llb_code_run.sv ====
/*
 * Counts consecutive primary-slot bytes that match one code pattern
 * and pulses once when the run reaches its minimum length.
 * Assumes byte_stb_i is high for one cycle per primary-slot byte.
 */
`include "llb_regs.svh"
`default_nettype none

module llb_code_run #(
   parameter logic [7:0] PATTERN = 8'h00,
   parameter logic [7:0] MIN_COUNT = 8'h01
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic byte_stb_i,
   input wire logic [7:0] byte_i,
   output logic reach_o,
   output logic run_o
);

   logic [7:0] count_q;
   logic match;

   assign match = ((byte_i ^ PATTERN) & `LLB_CODE_MASK) == 8'h00;

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         count_q <= 8'h00;
      end else if (byte_stb_i) begin
         if (!match) begin
            count_q <= 8'h00;
         end else if (count_q != MIN_COUNT) begin
            count_q <= count_q + 8'h01;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         reach_o <= 1'b0;
      end else begin
         reach_o <= byte_stb_i && match && (count_q == MIN_COUNT - 8'h01);
      end
   end

   assign run_o = (count_q == MIN_COUNT);

endmodule : llb_code_run

`default_nettype wire

// ==== sim/llb_det_properties.sv ====
/* Checker of the loopback detector top ports.
   Assumes it is bound to llb_detector with its timing parameters. */
`include "llb_regs.svh"
`default_nettype none
module llb_det_checker #(
   parameter logic [`LLB_WDOG_W-1:0] WDOG_CYCLES = 32'h64,
   parameter logic [`LLB_LOOPUP_W-1:0] LOOPUP_CYCLES = 40'hc8
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic byte_stb_i,
   input wire logic [`LLB_SLOT_W-1:0] slot_i,
   input wire logic [`LLB_SLOT_W-1:0] primary_slot_i,
   input wire logic [`LLB_NUM_SLOTS-1:0] slot_in_use_i,
   input wire logic [7:0] net_rx_byte_i,
   input wire logic [7:0] cust_rx_byte_i,
   input wire logic repeater_present_i,
   input wire logic loopup_timeout_en_i,
   input wire logic remote_loop_key_i,
   input wire logic remote_loop_button_i,
   input wire logic craft_cmd_valid_i,
   input wire logic [3:0] craft_cmd_i,
   input wire logic [7:0] net_tx_byte_o,
   input wire logic [7:0] cust_tx_byte_o,
   input wire logic net_loop_o,
   input wire logic cust_loop_o,
   input wire logic rpt_loop_req_o,
   input wire logic [2:0] arm_state_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic used_w;
   logic prim_w;
   logic [`LLB_WDOG_W-1:0] wd_q;
   logic [`LLB_LOOPUP_W-1:0] lu_q;
   assign used_w = slot_in_use_i[slot_i];
   assign prim_w = byte_stb_i && slot_i == primary_slot_i;
   // Cycles spent in one arming stage
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i || $changed(arm_state_o) || arm_state_o == 3'h0
          || arm_state_o == 3'h5) wd_q <= '0;
      else wd_q <= wd_q + 32'h1;
   end
   // Cycles looped with the timeout enabled
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i || !(net_loop_o || cust_loop_o) || !loopup_timeout_en_i)
         lu_q <= '0;
      else lu_q <= lu_q + 40'h1;
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   sequence s_cust_byte;
      byte_stb_i && used_w && cust_loop_o ##1 cust_loop_o;
   endsequence
   sequence s_net_byte;
      byte_stb_i && used_w && net_loop_o && !cust_loop_o ##1 net_loop_o;
   endsequence
   property p_cust_dp;
      s_cust_byte |-> net_tx_byte_o == 8'hff
         && cust_tx_byte_o == $past(cust_rx_byte_i);
   endproperty
   property p_net_dp;
      s_net_byte |-> net_tx_byte_o == $past(net_rx_byte_i)
         && cust_tx_byte_o == $past(net_rx_byte_i);
   endproperty
   property p_craft;
      craft_cmd_valid_i && craft_cmd_i == 4'h0 |=> net_loop_o && !cust_loop_o;
   endproperty
   property p_key;
      remote_loop_key_i && !cust_loop_o |=> cust_loop_o && !net_loop_o;
   endproperty
   property p_rpt;
      remote_loop_button_i && repeater_present_i && !rpt_loop_req_o
         |-> ##2 rpt_loop_req_o;
   endproperty
   property p_latch;
      $changed(arm_state_o) && arm_state_o == 3'h5 |=> net_loop_o;
   endproperty
   property p_prim;
      $changed(arm_state_o) && arm_state_o != 3'h0 |-> $past(prim_w, 2);
   endproperty
   property p_sel;
      $changed(arm_state_o) && arm_state_o == 3'h2 |->
         ($past(net_rx_byte_i, 2) & `LLB_CODE_MASK) == `LLB_OWN_SEL_BYTE;
   endproperty
   property p_wdog;
      wd_q <= WDOG_CYCLES + 32'h4;
   endproperty
   property p_loopup;
      lu_q <= LOOPUP_CYCLES + 40'h4;
   endproperty
   a_cust_dp: assert property (p_cust_dp)
      else $error("cust loop data");
   a_net_dp: assert property (p_net_dp)
      else $error("net loop data");
   a_craft: assert property (p_craft)
      else $error("craft net on");
   a_key: assert property (p_key)
      else $error("far key press");
   a_rpt: assert property (p_rpt)
      else $error("repeater request");
   a_latch: assert property (p_latch)
      else $error("latch no loop");
   a_prim: assert property (p_prim)
      else $error("non primary stage");
   a_sel: assert property (p_sel)
      else $error("wrong select");
   a_wdog: assert property (p_wdog)
      else $error("stage stuck");
   a_loopup: assert property (p_loopup)
      else $error("loop timeout");
endmodule : llb_det_checker
bind llb_detector llb_det_checker #(.WDOG_CYCLES(WDOG_CYCLES),
   .LOOPUP_CYCLES(LOOPUP_CYCLES)) u_llb_det_checker (.*);
`default_nettype wire

// ==== sim/llb_far_end.sv ====
/* Far-end model: test center byte stream over 24 slots.
   Assumes the bench picks the primary code byte and the pacing. */
`default_nettype none
module llb_far_end (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic slow_i,
   input wire logic [7:0] code_i,
   input wire logic [4:0] primary_slot_i,
   output logic byte_stb_o,
   output logic [4:0] slot_o,
   output logic [7:0] net_rx_o,
   output logic [7:0] cust_rx_o,
   output logic prim_o
);
   timeunit 1ns;
   timeprecision 1ps;
   integer seed = 81598;
   logic [4:0] cnt_q = 5'h00;
   logic gap_q = 1'b0;
   initial begin
      byte_stb_o = 1'b0;
      prim_o = 1'b0;
      slot_o = 5'h00;
      net_rx_o = 8'h00;
      cust_rx_o = 8'h00;
   end
   // Codes only in primary, random control bit
   always @(posedge clk_sys_i) begin
      net_rx_o <= 8'($random(seed));
      cust_rx_o <= 8'($random(seed));
      gap_q <= !sys_rst_i && slow_i && !gap_q;
      byte_stb_o <= !sys_rst_i && !gap_q;
      prim_o <= !sys_rst_i && !gap_q && cnt_q == primary_slot_i;
      if (sys_rst_i) cnt_q <= 5'h00;
      else if (!gap_q) begin
         slot_o <= cnt_q;
         cnt_q <= (cnt_q == 5'h17) ? 5'h00 : cnt_q + 5'h01;
         if (cnt_q == primary_slot_i)
            net_rx_o <= {1'($random(seed)), code_i[6:0]};
      end
   end
endmodule : llb_far_end
`default_nettype wire

// ==== sim/tb_llb_detector.sv ====
/* Bench of the loopback detector: far-end model feeds bytes, a bench
   model predicts datapath and loop states. Assumes the bound checker. */
`include "llb_regs.svh"
`default_nettype none
module tb_llb_detector;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WD = 6000;
   localparam int LU = 3000;
   logic clk_sys_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic slow = 1'b0;
   logic [7:0] code = 8'h00;
   logic [4:0] pslot = 5'h07;
   logic [23:0] in_use = 24'h000080;
   logic [2:0] tandem = 3'h0;
   logic rep = 1'b0;
   logic to_en = 1'b0;
   logic btn = 1'b0;
   logic key = 1'b0;
   logic cval = 1'b0;
   logic [3:0] ccmd = 4'h0;
   logic dp_on = 1'b0;
   logic [4:0] exp_lp = 5'h00;
   logic stb, prim, tx_stb, nloop, cloop, rnet, rcust, rpt;
   logic [4:0] slot;
   logic [7:0] nrx, crx, ntx, ctx;
   logic [2:0] arm;
   logic [16:0] q[$];
   logic [16:0] e;
   logic [15:0] x;
   integer seed = 81598;
   int bad_count = 0;
   int cmp_count = 0;
   always #4 clk_sys_i = ~clk_sys_i;
   llb_far_end u_llb_far_end (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
      .slow_i(slow), .code_i(code), .primary_slot_i(pslot),
      .byte_stb_o(stb), .slot_o(slot), .net_rx_o(nrx), .cust_rx_o(crx),
      .prim_o(prim));
   llb_detector #(.WDOG_CYCLES(32'(WD)), .LOOPUP_CYCLES(40'(LU)))
   u_llb_detector (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
      .byte_stb_i(stb), .slot_i(slot), .primary_slot_i(pslot),
      .slot_in_use_i(in_use), .net_rx_byte_i(nrx), .cust_rx_byte_i(crx),
      .tandem_index_i(tandem), .repeater_present_i(rep),
      .loopup_timeout_en_i(to_en), .remote_loop_button_i(btn),
      .remote_loop_key_i(key), .craft_cmd_valid_i(cval),
      .craft_cmd_i(ccmd), .tx_stb_o(tx_stb), .net_tx_byte_o(ntx),
      .cust_tx_byte_o(ctx), .net_loop_o(nloop), .cust_loop_o(cloop),
      .rmt_net_loop_req_o(rnet), .rmt_cust_loop_req_o(rcust),
      .rpt_loop_req_o(rpt), .arm_state_o(arm));
   task chk(input logic [15:0] seen, input logic [15:0] want);
      cmp_count++;
      if (seen !== want) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
      end
   endtask : chk
   task conclude;
      $display("Compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : conclude
   task wt(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask : wt
   task st(input logic [2:0] a);
      chk({11'h000, nloop, cloop, rnet, rcust, rpt}, {11'h000, exp_lp});
      chk({13'h0000, arm}, {13'h0000, a});
   endtask : st
   task send(input logic [7:0] c, input int n);
      code <= c;
      @(posedge clk_sys_i);
      repeat (n) begin
         @(posedge clk_sys_i);
         while (!prim) @(posedge clk_sys_i);
      end
      code <= 8'h00;
      wt(4);
   endtask : send
   task act(input int w, input logic [3:0] c);
      if (w == 0) btn <= 1'b1;
      else if (w == 1) key <= 1'b1;
      else begin
         cval <= 1'b1;
         ccmd <= c;
      end
      @(posedge clk_sys_i);
      btn <= 1'b0;
      key <= 1'b0;
      cval <= 1'b0;
      wt(4);
   endtask : act
   task dpw;
      dp_on <= 1'b1;
      wt(80);
      dp_on <= 1'b0;
      wt(2);
   endtask : dpw
   // Predicted bytes per strobe, compared one cycle later
   always @(posedge clk_sys_i) begin
      if (tx_stb && q.size() > 0) begin
         e = q.pop_front();
         if (e[16]) chk({ntx, ctx}, e[15:0]);
      end
      if (stb && !sys_rst_i) begin
         if (in_use[slot] && exp_lp[3]) x = {8'hff, crx};
         else if (in_use[slot] && exp_lp[4]) x = {nrx, nrx};
         else x = {crx, nrx};
         q.push_back({dp_on, x});
      end
   end
   initial begin
      wt(60000);
      bad_count++;
      conclude();
   end
   initial begin
      in_use <= 24'($random(seed)) | 24'h000080;
      wt(2);
      sys_rst_i <= 1'b0;
      wt(2);
      st(3'h0);
      slow <= 1'b1;
      dpw;
      slow <= 1'b0;
      dpw;
      send(`LLB_TIP_BYTE, 34);
      wt(30);
      st(3'h0);
      send(`LLB_TIP_BYTE, 35);
      st(3'h1);
      send(8'h41, 35);
      st(3'h1);
      send(`LLB_OWN_SEL_BYTE, 35);
      st(3'h2);
      send(`LLB_ENA_BYTE, 100);
      st(3'h3);
      send(`LLB_FAR_VOICE_BYTE, 32);
      exp_lp = 5'h10;
      st(3'h5);
      dpw;
      wt(300);
      st(3'h5);
      send(`LLB_TIP_BYTE, 35);
      exp_lp = 5'h00;
      st(3'h0);
      // Break the marker run so the next run counts afresh
      wt(30);
      send(`LLB_TIP_BYTE, 35);
      st(3'h1);
      wt(WD - 60);
      st(3'h1);
      wt(100);
      st(3'h0);
      tandem <= 3'h1;
      send(`LLB_TIP_BYTE, 35);
      send(`LLB_OWN_SEL_BYTE, 35);
      send(`LLB_ENA_BYTE, 100);
      send(`LLB_ONES_BYTE, 35);
      st(3'h4);
      send(`LLB_ENA_BYTE, 100);
      send(`LLB_FAR_VOICE_BYTE, 32);
      exp_lp = 5'h10;
      st(3'h5);
      send(`LLB_TIP_BYTE, 35);
      exp_lp = 5'h00;
      st(3'h0);
      tandem <= 3'h0;
      act(2, 4'h0);
      act(2, 4'h2);
      exp_lp = 5'h08;
      st(3'h0);
      dpw;
      for (int i = 0; i < 10; i++) begin
         act(2, 4'(i));
         exp_lp[4 - i / 2] = !i[0];
         if (i == 0) exp_lp[3] = 1'b0;
         st(3'h0);
      end
      act(1, 4'h0);
      exp_lp = 5'h08;
      st(3'h0);
      act(1, 4'h0);
      act(0, 4'h0);
      exp_lp = 5'h04;
      st(3'h0);
      act(0, 4'h0);
      exp_lp = 5'h00;
      st(3'h0);
      rep <= 1'b1;
      act(0, 4'h0);
      act(1, 4'h0);
      exp_lp = 5'h09;
      st(3'h0);
      to_en <= 1'b1;
      wt(LU + 40);
      exp_lp = 5'h00;
      st(3'h0);
      conclude();
   end
endmodule : tb_llb_detector
`default_nettype wire
